/* inc/flash_pkg.sv */
/*
  Shared constants for the serial flash status and read command logic:
  opcodes, status bit positions, reset values, lengths and timing.
  Assumes a 250 MHz system clock sampling the serial pins.
*/
package flash_pkg;
  // Opcodes
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
  localparam logic [7:0] OP_SR_READ_LO = 8'h05;
  localparam logic [7:0] OP_SR_READ_HI = 8'h35;
  localparam logic [7:0] OP_SR_READ_QB = 8'h15;
  localparam logic [7:0] OP_SR_WRITE   = 8'h01;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST       = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  // Status bit positions
  localparam int BIT_BUSY        = 0;
  localparam int BIT_LATCH       = 1;
  localparam int BIT_LOCK0       = 7;
  localparam int BIT_LOCK1       = 8;
  localparam int BIT_QUAD_ENABLE = 9;
  localparam int BIT_COMPLEMENT  = 14;
  localparam logic [15:0] SR_KEEP_MASK = 16'h8403;
  localparam logic [15:0] SR_RESET     = 16'h0000;
  localparam logic [1:0]  CONT_CODE    = 2'b10;
  // Lengths in bits or clocks
  localparam logic [5:0] CMD_BITS     = 6'd8;
  localparam logic [5:0] ADDR_BITS    = 6'd24;
  localparam logic [5:0] ADDR_MODE    = 6'd32;
  localparam logic [5:0] SR_ONE_BYTE  = 6'd8;
  localparam logic [5:0] SR_TWO_BYTE  = 6'd16;
  localparam logic [5:0] DUMMY_SERIAL = 6'd8;
  localparam logic [5:0] DUMMY_P0     = 6'd4;
  localparam logic [5:0] DUMMY_P1     = 6'd6;
  localparam logic [5:0] DUMMY_P2     = 6'd8;
  localparam logic [5:0] DUMMY_P3     = 6'd8;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  // Frame states
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b000_0001,
    ST_CMD    = 7'b000_0010,
    ST_ADDR   = 7'b000_0100,
    ST_DUMMY  = 7'b000_1000,
    ST_DATA   = 7'b001_0000,
    ST_SROUT  = 7'b010_0000,
    ST_SRIN   = 7'b100_0000,
    ST_IGNORE = 7'b000_0000
  } frame_state_t;
endpackage : flash_pkg

/* rtl/flash_cmd.sv */
/*
  Serial flash command logic: write latch control, volatile status
  write enable, status read and write, single, dual and quad reads with
  continuous dual IO mode, plus the read data FIFO.
  Assumes the host drives chip select, serial clock and data lines, and
  an array engine streams bytes from read_addr after read_start.
*/
// What this block does
// [R1] Write disable clears the write latch
// [R2] Latch clears on reset and operation completion
// [R3] Volatile enable dropped unless status write follows
// [R4] Volatile enable updates status without write cycle
// [R5] Status read anytime, repeats while selected
// [R6] 05H gives low byte, 35H high
// [R7] 15H only in quad mode, on line zero
// [R8] Host polls busy flag before new commands
// [R9] Status write needs latch set first
// [R10] Status write keeps bits 15, 10, 1, 0
// [R11] Status write needs exactly 8 or 16 bits
// [R12] One byte clears complement, quad enable too outside quad command mode
// [R13] Status write starts timed busy cycle
// [R14] Status writes ignored in hardware protection
// [R15] Read 03H: address in, data out, incrementing
// [R16] Reads rejected while cycle in progress, except continuous dual IO frames
// [R17] Fast read: address, dummy byte, data
// [R18] Quad mode dummy clocks from read parameter
// [R19] Dual output read, two lines out
// [R20] Quad output read needs quad enable
// [R21] Dual IO: address and mode on two lines
// [R22] Mode bits 10 skip next opcode
// [R23] Write enable sets the write latch
// [R24] Line one odd bits, line zero even
// [R25] MSB first; chip select high ends frame
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module read_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = wr_ptr == rd_ptr;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : read_fifo

////////////////////////////////////////////////////////////////////////
module flash_cmd
  import flash_pkg::*;
#(
  parameter int STATUS_WRITE_DURATION_NS = 5_000_000,
  parameter int FIFO_DEPTH               = 16
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Flash pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic        wp_n,
  // Configuration
  input  wire logic        quad_command_mode,
  input  wire logic [1:0]  read_param,
  // Other operations
  input  wire logic        ext_busy,
  input  wire logic        ext_done,
  // Status
  output logic      [15:0] status,
  // Array read side
  output logic      [23:0] read_addr,
  output logic             read_start,
  output logic             read_stop,
  input  wire logic        fill_valid,
  output logic             fill_ready,
  input  wire logic [7:0]  fill_data
);
  localparam int SW_CYCLES =
    (STATUS_WRITE_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  frame_state_t state;
  frame_state_t next_state;
  logic [2:0]  cs_q;
  logic [2:0]  sclk_q;
  logic [3:0]  io_q1;
  logic [3:0]  io_s;
  logic [1:0]  wp_q;
  logic        cs_s;
  logic        cs_rise;
  logic        cs_fall;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [31:0] sh;
  logic [31:0] next_sh;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [2:0]  lanes_in;
  logic [2:0]  lanes_out;
  logic [7:0]  cmd;
  logic        extra;
  logic        cmd_ok;
  logic        cont;
  logic [5:0]  addr_len;
  logic [5:0]  dummy_len;
  logic        addr_done;
  logic [7:0]  ob;
  logic [2:0]  obits;
  logic [7:0]  cur;
  logic [7:0]  sr_byte;
  logic [3:0]  next_io;
  logic [3:0]  oe_mask;
  logic        out_phase;
  logic        pop;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic [15:0] sr;
  logic [15:0] sr_new;
  logic        write_latch_flag;
  logic        vol_enable;
  logic [31:0] sw_cnt;
  logic        op_in_progress_flag;
  logic        hw_prot;
  logic        sr_write_ok;
  logic        latch_set;
  logic        cmd_decoded;

  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] d,
                                           input logic [2:0] n);
    case (n)
      3'd2:    shift_in = {s[29:0], d[1:0]};
      3'd4:    shift_in = {s[27:0], d};
      default: shift_in = {s[30:0], d[0]};
    endcase
  endfunction : shift_in

  function automatic frame_state_t decode(input logic [7:0] op, input logic busy,
                                          input logic quad, input logic qe);
    case (op)
      OP_SR_READ_LO, OP_SR_READ_HI: decode = ST_SROUT;
      OP_SR_READ_QB: decode = quad ? ST_SROUT : ST_IGNORE;
      OP_SR_WRITE:   decode = ST_SRIN;
      OP_READ, OP_FAST: decode = busy ? ST_IGNORE : ST_ADDR;
      OP_DUAL_OUT, OP_DUAL_IO: decode = (busy || quad) ? ST_IGNORE : ST_ADDR;
      OP_QUAD_OUT: decode = (busy || quad || !qe) ? ST_IGNORE : ST_ADDR;
      default:     decode = ST_IGNORE;
    endcase
  endfunction : decode

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q   <= 3'b111;
      sclk_q <= 3'b000;
      io_q1  <= 4'h0;
      io_s   <= 4'h0;
      wp_q   <= 2'b11;
    end else begin
      cs_q   <= {cs_q[1:0], cs_n};
      sclk_q <= {sclk_q[1:0], sclk};
      io_q1  <= io_in;
      io_s   <= io_q1;
      wp_q   <= {wp_q[0], wp_n};
    end
  end

  assign cs_s      = cs_q[1];
  assign cs_rise   = cs_q[1] && !cs_q[2];
  assign cs_fall   = !cs_q[1] && cs_q[2];
  assign sclk_rise = sclk_q[1] && !sclk_q[2] && !cs_s;
  assign sclk_fall = !sclk_q[1] && sclk_q[2] && !cs_s;
  assign op_in_progress_flag = (sw_cnt != 32'h0000_0000) || ext_busy;
  assign hw_prot   = sr[BIT_LOCK1] || (sr[BIT_LOCK0] && !wp_q[1]);             // [R14]
  assign status    = {sr[15:2], write_latch_flag, op_in_progress_flag};

  ////////////////////////////////////////////////////////////////////
  // Frame decode
  assign addr_len  = (cmd == OP_DUAL_IO) ? ADDR_MODE : ADDR_BITS;
  assign cmd_ok    = (state == ST_IGNORE) && !extra;
  assign addr_done = sclk_rise && (state == ST_ADDR) && (next_state != ST_ADDR);
  assign cmd_decoded = sclk_rise && (state == ST_CMD) && (next_state != ST_CMD);

  always_comb begin
    case (read_param)                                                          // [R18]
      2'd0:    dummy_len = DUMMY_P0;
      2'd1:    dummy_len = DUMMY_P1;
      2'd2:    dummy_len = DUMMY_P2;
      default: dummy_len = DUMMY_P3;
    endcase
    if (cmd == OP_READ || cmd == OP_DUAL_IO) begin
      dummy_len = 6'd0;                                                        // [R15] [R21]
    end else if (!quad_command_mode) begin
      dummy_len = DUMMY_SERIAL;                                                // [R17] [R19]
    end
  end

  always_comb begin
    lanes_in = 3'd1;
    if (quad_command_mode) begin
      lanes_in = 3'd4;
    end else if (state == ST_ADDR && cmd == OP_DUAL_IO) begin
      lanes_in = 3'd2;                                                         // [R21] [R24]
    end
    next_sh    = shift_in(sh, io_s, lanes_in);                                 // [R25]
    next_cnt   = cnt + {3'd0, lanes_in};
    next_state = state;
    case (state)
      ST_CMD: begin
        if (next_cnt == CMD_BITS) begin
          next_state = decode(next_sh[7:0], op_in_progress_flag,               // [R16] [R20]
                              quad_command_mode, sr[BIT_QUAD_ENABLE]);
        end
      end
      ST_ADDR: begin
        if (next_cnt == addr_len) begin
          next_state = (dummy_len == 6'd0) ? ST_DATA : ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (cnt + 6'd1 == dummy_len) begin
          next_state = ST_DATA;
        end
      end
      default: next_state = state;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt   <= 6'd0;
      sh    <= 32'h0000_0000;
      cmd   <= 8'h00;
      extra <= 1'b0;
    end else if (cs_s) begin
      state <= ST_IDLE;                                                        // [R25]
    end else if (cs_fall) begin
      state <= cont ? ST_ADDR : ST_CMD;                                        // [R22]
      cmd   <= cont ? OP_DUAL_IO : 8'h00;
      cnt   <= 6'd0;
      extra <= 1'b0;
    end else if (sclk_rise) begin
      sh    <= next_sh;
      state <= next_state;
      if (next_state != state) begin
        cnt <= 6'd0;
      end else if (state == ST_DUMMY) begin
        cnt <= cnt + 6'd1;
      end else if (!cnt[5]) begin
        cnt <= next_cnt;                                                       // [R11]
      end
      if (state == ST_CMD) begin
        cmd <= next_sh[7:0];
      end
      if (state == ST_IGNORE) begin
        extra <= 1'b1;
      end
    end
  end

  // Continuous dual IO mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cont <= 1'b0;
    end else if (addr_done && cmd == OP_DUAL_IO) begin
      cont <= next_sh[5:4] == CONT_CODE;                                       // [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output shifter
  assign out_phase = (state == ST_DATA) || (state == ST_SROUT);
  assign pop       = sclk_fall && (state == ST_DATA) && (obits == 3'd0);
  assign cur       = (obits != 3'd0) ? ob : (state == ST_DATA) ? fifo_data : sr_byte;

  always_comb begin
    case (cmd)
      OP_SR_READ_HI: sr_byte = status[15:8];                                   // [R6]
      OP_SR_READ_QB: sr_byte = {4{status[1:0]}};                               // [R7]
      default:       sr_byte = status[7:0];                                    // [R6]
    endcase
    lanes_out = 3'd1;
    if (quad_command_mode && cmd != OP_SR_READ_QB) begin
      lanes_out = 3'd4;
    end else if (state == ST_DATA && (cmd == OP_DUAL_OUT || cmd == OP_DUAL_IO)) begin
      lanes_out = 3'd2;                                                        // [R19] [R21]
    end else if (state == ST_DATA && cmd == OP_QUAD_OUT) begin
      lanes_out = 3'd4;                                                        // [R20]
    end
    case (lanes_out)
      3'd4: begin
        next_io = cur[7:4];
        oe_mask = 4'hF;
      end
      3'd2: begin
        next_io = {2'b00, cur[7:6]};                                           // [R24]
        oe_mask = 4'h3;
      end
      default: begin
        next_io = (cmd == OP_SR_READ_QB) ? {3'b000, cur[7]} : {2'b00, cur[7], 1'b0};
        oe_mask = (cmd == OP_SR_READ_QB) ? 4'h1 : 4'h2;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_out <= 4'h0;
      io_oe  <= 4'h0;
      ob     <= 8'h00;
      obits  <= 3'd0;
    end else if (cs_s || cs_fall) begin
      io_oe  <= 4'h0;                                                          // [R25]
      obits  <= 3'd0;
    end else if (sclk_fall && out_phase) begin
      io_out <= next_io;                                                       // [R5] [R15]
      io_oe  <= oe_mask;
      ob     <= cur << lanes_out;
      obits  <= obits + lanes_out;
    end
  end

  // Array address, incremented per byte taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_addr  <= 24'h00_0000;
      read_start <= 1'b0;
      read_stop  <= 1'b0;
    end else begin
      read_start <= addr_done;
      read_stop  <= cs_rise;
      if (addr_done) begin
        read_addr <= (cmd == OP_DUAL_IO) ? next_sh[31:8] : next_sh[23:0];      // [R15]
      end else if (pop) begin
        read_addr <= read_addr + 24'h00_0001;                                  // [R15]
      end
    end
  end

  read_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .flush     (cs_s),                     // Held empty while deselected
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (fill_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Status register, write latch and timed write cycle
  assign latch_set   = cs_rise && cmd == OP_WR_ENABLE && cmd_ok;
  assign sr_write_ok = cs_rise && state == ST_SRIN &&
                       (cnt == SR_ONE_BYTE || cnt == SR_TWO_BYTE) &&           // [R11]
                       (write_latch_flag || vol_enable) && !hw_prot &&        // [R9] [R14]
                       !op_in_progress_flag;

  always_comb begin
    if (cnt == SR_ONE_BYTE) begin
      sr_new = {sr[15:8], sh[7:0]};
      sr_new[BIT_COMPLEMENT] = 1'b0;                                           // [R12]
      if (!quad_command_mode) begin
        sr_new[BIT_QUAD_ENABLE] = 1'b0;                                        // [R12]
      end
    end else begin
      sr_new = {sh[7:0], sh[15:8]};
    end
    sr_new = (sr_new & ~SR_KEEP_MASK) | (sr & SR_KEEP_MASK);                   // [R10]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sr     <= SR_RESET;
      sw_cnt <= 32'h0000_0000;
    end else if (sr_write_ok) begin
      sr     <= sr_new;
      sw_cnt <= vol_enable ? 32'h0000_0000 : 32'(SW_CYCLES);                   // [R4] [R13]
    end else if (sw_cnt != 32'h0000_0000) begin
      sw_cnt <= sw_cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_latch_flag <= 1'b0;                                                // [R2]
    end else if (latch_set) begin
      write_latch_flag <= 1'b1;                                                // [R23]
    end else if ((cs_rise && cmd == OP_WR_DISABLE && cmd_ok) ||                // [R1]
                 sw_cnt == 32'h0000_0001 || ext_done) begin
      write_latch_flag <= 1'b0;                                                // [R2]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vol_enable <= 1'b0;
    end else if (cs_rise && cmd == OP_VOL_ENABLE && cmd_ok) begin
      vol_enable <= 1'b1;
    end else if ((cmd_decoded && next_sh[7:0] != OP_SR_WRITE) ||
                 (cs_rise && state == ST_SRIN)) begin
      vol_enable <= 1'b0;                                                      // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_write_disable_cmd_clear: // [R1]
    assert property (cs_rise && cmd == OP_WR_DISABLE && cmd_ok |=> !write_latch_flag)
    else $error("write disable left latch set");
  a_write_enable_cmd_set: // [R23]
    assert property (latch_set |=> write_latch_flag ##1 (write_latch_flag || ext_done ||
                     $past(ext_done)))
    else $error("write enable did not set latch");
  a_done_clear: // [R2]
    assert property (sw_cnt == 32'h0000_0001 && !latch_set |=> !write_latch_flag)
    else $error("latch not cleared at write end");
  a_vol_discard: // [R3]
    assert property (cmd_decoded && next_sh[7:0] != OP_SR_WRITE |=> !vol_enable)
    else $error("volatile enable kept across command");
  a_vol_no_cycle: // [R4]
    assert property (sr_write_ok && vol_enable && !ext_done |=>
                     sw_cnt == 32'h0000_0000 && $stable(write_latch_flag))
    else $error("volatile write started a cycle");
  a_busy_start: // [R13]
    assert property (sr_write_ok && !vol_enable |=> status[BIT_BUSY] [*8])
    else $error("busy flag not raised by status write");
  a_keep_bits: // [R10]
    assert property (sr_write_ok |=> status[15] == $past(status[15]) &&
                     status[10] == $past(status[10]))
    else $error("protected status bits changed");
  a_one_byte: // [R12]
    assert property (sr_write_ok && cnt == SR_ONE_BYTE |=> !status[BIT_COMPLEMENT])
    else $error("complement bit not cleared");
  a_hw_protect: // [R14]
    assert property (cs_rise && hw_prot |=> $stable(sr))
    else $error("status write in protected mode");
  a_read_reject: // [R16]
    assert property (sclk_rise && state == ST_CMD && next_cnt == CMD_BITS &&
                     next_sh[7:0] == OP_READ && op_in_progress_flag |=> state == ST_IGNORE)
    else $error("read accepted while busy");
  a_quad_gate: // [R20]
    assert property (cmd_decoded && next_sh[7:0] == OP_QUAD_OUT &&
                     !sr[BIT_QUAD_ENABLE] |=> state == ST_IGNORE)
    else $error("quad read without quad enable");
  a_cont_skip: // [R22]
    assert property (cs_fall && cont |=> state == ST_ADDR && cmd == OP_DUAL_IO)
    else $error("continuous mode did not skip opcode");
  a_frame_end: // [R25]
    assert property (cs_rise |=> state == ST_IDLE && io_oe == 4'h0)
    else $error("frame not ended by chip select");
endmodule : flash_cmd

/* testbench/flash_host.sv */
/*
  Host controller model: chip select, serial clock and data lines.
  Assumes the device drives io_out under io_oe; sclk idles low.
*/
`timescale 1ns/1ns
module flash_host (
  // Clock
  input  wire logic       clk,
  // Pins
  output logic            cs_n,
  output logic            sclk,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [3:0] drv;
  logic [3:0] hoe;
  // Undriven lines show the inverse of the last value
  assign io_in = (io_oe & io_out) | (~io_oe & hoe & drv) | (~io_oe & ~hoe & ~drv);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv  = 4'h0;
    hoe  = 4'h0;
  end
  task automatic tick();
    #16 sclk = 1'b1;
    #16 sclk = 1'b0;
  endtask : tick
  task automatic start();
    @(negedge clk) cs_n = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    #20 cs_n = 1'b1;
    hoe = 4'h0;
    #40;
  endtask : stop
  // MSB first, line one odd bits when dual
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 8; i > 0; i -= n) begin
      hoe = 4'((1 << n) - 1);
      drv = 4'(b >> (i - n)) & hoe;
      tick();
    end
  endtask : put
  // Lane code 0 samples io0 alone, 1 samples io1
  task automatic get(output logic [7:0] b, input int n);
    b = 8'h00;
    hoe = 4'h0;
    for (int i = 0; i < 8; i += (n == 0) ? 1 : n) begin
      #16 sclk = 1'b1;
      #13 b = (n < 2) ? {b[6:0], io_out[n]} : (b << n) | 8'(io_out & 4'((1 << n) - 1));
      #3 sclk = 1'b0;
    end
  endtask : get
endmodule : flash_host

/* testbench/tb.sv */
/*
  Self-checking bench for flash_cmd, frames sent through the host model.
  Assumes a 4 ns clock and a 400 ns status write (100 cycles).
*/
`timescale 1ns/1ns
module tb;
  import flash_pkg::*;
  logic        clk, reset_n, cs_n, sclk, wp_n, qmode, ext_busy, ext_done;
  logic        read_start, read_stop, fill_ready, fill_valid = 1'b0;
  logic [3:0]  io_in, io_out, io_oe;
  logic [1:0]  rp;
  logic [15:0] status;
  logic [23:0] read_addr, cnt = 24'h00_0000;
  logic [7:0]  b;
  int          bad_count, checked, ln;
  int          dmt[4] = '{4, 6, 8, 8};
  flash_cmd #(.STATUS_WRITE_DURATION_NS(400)) flash_cmd_i (.clk(clk), .reset_n(reset_n),
    .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .wp_n(wp_n),
    .quad_command_mode(qmode), .read_param(rp), .ext_busy(ext_busy), .ext_done(ext_done),
    .status(status), .read_addr(read_addr), .read_start(read_start), .read_stop(read_stop),
    .fill_valid(fill_valid), .fill_ready(fill_ready), .fill_data(cnt[7:0] ^ 8'h5a));
  flash_host flash_host_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Array: streams bytes from the loaded address until the frame ends
  always @(posedge clk) begin
    if (read_start) begin
      cnt        <= read_addr;
      fill_valid <= 1'b1;
    end else if (read_stop) begin
      fill_valid <= 1'b0;
    end else if (fill_valid && fill_ready) begin
      cnt <= cnt + 24'h00_0001;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [23:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic cmd(input logic [7:0] op);
    flash_host_i.start();
    flash_host_i.put(op, ln);
    flash_host_i.stop();
  endtask : cmd
  task automatic status_write_cmd(input logic [15:0] d, input int nb);
    flash_host_i.start();
    flash_host_i.put(OP_SR_WRITE, ln);
    flash_host_i.put(d[7:0], ln);
    if (nb == 16) flash_host_i.put(d[15:8], ln);
    if (nb == 12) repeat (4) flash_host_i.tick();
    flash_host_i.stop();
  endtask : status_write_cmd
  task automatic srd(input logic [7:0] op, input int n, input logic [3:0] oe);
    flash_host_i.start();
    flash_host_i.put(op, ln);
    flash_host_i.get(b, n);
    check("sr_oe", io_oe, oe);
    flash_host_i.stop();
  endtask : srd
  task automatic rd(input logic [7:0] op, input int al, dm, dl, ok, input logic [23:0] a,
                    input logic [7:0] md);
    flash_host_i.start();
    if (op !== 8'h00) flash_host_i.put(op, ln);
    for (int i = 2; i >= 0; i--) flash_host_i.put(a[i*8 +: 8], al);
    if (al == 2) flash_host_i.put(md, 2);
    repeat (dm) flash_host_i.tick();
    for (int k = 0; k < 2; k++) begin
      flash_host_i.get(b, dl);
      if (ok) check("rd_data", b, 8'(a + k) ^ 8'h5a);
    end
    if (ok) check("fifo_full", fill_ready, 1'b0);
    else check("rd_oe", io_oe, 4'h0);
    flash_host_i.stop();
  endtask : rd
  //////////////////////////////////////////////////////////////////////
  task automatic t_status();
    cmd(OP_WR_ENABLE);
    flash_host_i.start();
    flash_host_i.put(OP_SR_READ_LO, 1);
    flash_host_i.get(b, 1);
    check("sr_lo", b, 8'h02);
    flash_host_i.get(b, 1);
    check("sr_again", b, 8'h02);
    flash_host_i.stop();
    srd(OP_SR_READ_QB, 0, 4'h0);
    cmd(OP_WR_DISABLE);
    check("latch_off", status[1], 1'b0);
    cmd(OP_WR_ENABLE);
    @(posedge clk) ext_done <= 1'b1;
    @(posedge clk) ext_done <= 1'b0;
    @(posedge clk) ext_busy <= 1'b1;
    @(posedge clk);
    check("latch_done", status[1:0], 2'b01);
    rd(OP_READ, 1, 0, 1, 0, 24'h00_0100, 8'h00);
    @(posedge clk) ext_busy <= 1'b0;
    $display("t_status done");
  endtask : t_status
  task automatic t_status_write_cmd();
    status_write_cmd(16'hc607, 16);
    check("sr_nolatch", status, 16'h0000);
    cmd(OP_WR_ENABLE);
    status_write_cmd(16'hc607, 16);
    check("sr_write", status, 16'h4207);
    repeat (110) @(posedge clk);
    check("sr_done", status, 16'h4204);
    srd(OP_SR_READ_HI, 1, 4'h2);
    check("sr_hi", b, 8'h42);
    cmd(OP_WR_ENABLE);
    status_write_cmd(16'h0008, 12);
    check("sr_short", status, 16'h4206);
    status_write_cmd(16'h0008, 8);
    check("sr_byte", status, 16'h000b);
    repeat (110) @(posedge clk);
    $display("t_status_write_cmd done");
  endtask : t_status_write_cmd
  task automatic t_read();
    rd(OP_READ, 1, 0, 1, 1, 24'h12_34fe, 8'h00);
    rd(OP_FAST, 1, 8, 1, 1, 24'h00_0010, 8'h00);
    rd(OP_DUAL_OUT, 1, 8, 2, 1, 24'h00_0020, 8'h00);
    rd(OP_QUAD_OUT, 1, 8, 4, 0, 24'h00_0030, 8'h00);
    rd(OP_DUAL_IO, 2, 0, 2, 1, 24'h00_0040, 8'h20);
    rd(8'h00, 2, 0, 2, 1, 24'h00_0050, 8'h00);
    srd(OP_SR_READ_LO, 1, 4'h2);
    $display("t_read done");
  endtask : t_read
  task automatic t_vol();
    cmd(OP_VOL_ENABLE);
    status_write_cmd(16'h0200, 16);
    check("vol", status, 16'h0200);
    cmd(OP_VOL_ENABLE);
    srd(OP_SR_READ_LO, 1, 4'h2);
    status_write_cmd(16'h0000, 16);
    check("vol_lost", status, 16'h0200);
    cmd(OP_VOL_ENABLE);
    status_write_cmd(16'h0280, 16);
    @(posedge clk) wp_n <= 1'b0;
    cmd(OP_VOL_ENABLE);
    status_write_cmd(16'h0000, 16);
    check("wp_lock", status, 16'h0280);
    @(posedge clk) wp_n <= 1'b1;
    cmd(OP_VOL_ENABLE);
    status_write_cmd(16'h0380, 16);
    cmd(OP_VOL_ENABLE);
    status_write_cmd(16'h0000, 16);
    check("locked", status, 16'h0380);
    $display("t_vol done");
  endtask : t_vol
  task automatic t_quad();
    rd(OP_QUAD_OUT, 1, 8, 4, 1, 24'h00_0060, 8'h00);
    @(posedge clk) qmode <= 1'b1;
    ln = 4;
    cmd(OP_WR_ENABLE);
    srd(OP_SR_READ_QB, 0, 4'h1);
    check("sr_qb", b, 8'haa);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk) rp <= 2'(p);
      rd(OP_FAST, 4, dmt[p], 4, 1, 24'h00_0100 + 24'(p * 16), 8'h00);
    end
    $display("t_quad done");
  endtask : t_quad
  //////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    qmode = 1'b0;
    rp = 2'b00;
    ext_busy = 1'b0;
    ext_done = 1'b0;
    ln = 1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_status();
    t_status_write_cmd();
    t_read();
    t_vol();
    t_quad();
    summarize();
  end
  initial begin
    #300_000;
    bad_count++;
    summarize();
  end
endmodule : tb
